// [design/rx_port.sv]
// What this block does
// R1: Data changes only with selected interface clock
// R2: Clock source chosen per channel by latch
// R3: Full rate: data changes on true rising
// R4: Half rate: data changes on both edges
// R5: Bypass: low raw bits onto status
// R6: Bypass: top status bit flags comma
// R7: Decoder on: status carries character status
// R8: Interface clock runs continuously at chosen rate
// R9: Reference source: clock aligned with output data
// R10: Half ref, recovered source: rate setting rules
// R11: Half ref, reference source: rate setting ignored
// R12: Reset puts latches and state to known
// R13: Controller holds reset for minimum width
// R14: Source latch zero selects recovered clock
// R15: Each of four channels fully independent
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps

`include "rx_port_cfg.svh"

module rx_port #(
  parameter int REF_DIV = `REF_DIV_DEFAULT
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input rx_port_pkg::lane_in_t [rx_port_pkg::NCH-1:0] lane_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  output rx_port_pkg::lane_out_t [rx_port_pkg::NCH-1:0] rx_char_out,
  output logic [rx_port_pkg::NCH-1:0] rx_iface_clock_out,
  output logic [rx_port_pkg::NCH-1:0] rx_iface_clock_n_out
);
  import rx_port_pkg::*;

  port_state_t q;
  port_state_t d;
  logic [NCH-1:0] ref_tick;

  // One reference tick source per channel; all share DIV and reset, so their ticks fall in the same cycles
  for (genvar g = 0; g < NCH; g++) begin : g_ref
    ref_tick_gen #(
      .DIV(REF_DIV)
    ) u_ref (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .tick_out(ref_tick[g])
    ); // R15
  end

  always_comb begin
    logic src_ref;
    logic rate_half;
    logic ref_half;
    logic bypass;
    logic upd;
    logic half;
    d = q;
    src_ref = 1'b0;
    rate_half = 1'b0;
    ref_half = 1'b0;
    bypass = 1'b0;
    upd = 1'b0;
    half = 1'b0;
    d.rdata = 32'h0000_0000;

    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `OFS_CTRL: d.ctrl = reg_wdata_in; // R2
        `OFS_IRQ_STAT: d.irq_stat = q.irq_stat & ~reg_wdata_in[7:0];
        `OFS_IRQ_MASK: d.irq_mask = reg_wdata_in[7:0];
        default: ;
      endcase
    end

    for (int ch = 0; ch < NCH; ch++) begin
      src_ref = q.ctrl[ch * `CTL_STRIDE + `CTL_SRC_BIT]; // R14
      rate_half = q.ctrl[ch * `CTL_STRIDE + `CTL_RATE_BIT];
      ref_half = q.ctrl[ch * `CTL_STRIDE + `CTL_REFHALF_BIT];
      bypass = q.ctrl[ch * `CTL_STRIDE + `CTL_BYPASS_BIT];
      // Character event of the selected source
      upd = src_ref ? ref_tick[ch] : lane_in[ch].strobe; // R2
      half = (src_ref && ref_half) ? 1'b1 : rate_half; // R10 R11
      if (upd) begin
        if (bypass) begin
          d.lane[ch].data = lane_in[ch].raw[9:2]; // R5
          d.lane[ch].status = {lane_in[ch].comma, lane_in[ch].raw[1:0]}; // R5 R6
        end else begin
          d.lane[ch].data = lane_in[ch].dec;
          d.lane[ch].status = lane_in[ch].stat; // R7
        end
        // Clock edge lands in the same cycle as the data change
        d.clk_t[ch] = half ? ~q.clk_t[ch] : 1'b1; // R1 R3 R4 R9
        d.irq_stat[`IRQ_CHAR_BASE + ch] = 1'b1;
        if (bypass && lane_in[ch].comma) begin
          d.irq_stat[`IRQ_COMMA_BASE + ch] = 1'b1;
        end
      end else if (!half) begin
        // Full rate clock falls one cycle after its rising edge
        d.clk_t[ch] = 1'b0; // R3 R8
      end
      d.clk_n[ch] = ~d.clk_t[ch]; // R3
    end

    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `OFS_CTRL: d.rdata = q.ctrl;
        `OFS_LIVE: d.rdata = {24'h00_0000, q.clk_n, q.clk_t};
        `OFS_IRQ_STAT: d.rdata = {24'h00_0000, q.irq_stat};
        `OFS_IRQ_MASK: d.rdata = {24'h00_0000, q.irq_mask};
        default: d.rdata = 32'h0000_0000;
      endcase
    end

    d.irq = |(d.irq_stat & d.irq_mask);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      q <= '0; // R12
      q.ctrl <= `CTRL_RST; // R12
      q.irq_mask <= `IRQ_MASK_RST;
      q.clk_n <= '1;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_out = q.rdata;
  assign irq_out = q.irq;
  assign rx_char_out = q.lane;
  assign rx_iface_clock_out = q.clk_t;
  assign rx_iface_clock_n_out = q.clk_n;

endmodule : rx_port

// [design/rx_port_cfg.svh]
`ifndef RX_PORT_CFG_SVH
`define RX_PORT_CFG_SVH

// Channel count
`define NUM_CH 4

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_LIVE 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0C

// Per-channel fields of the control register, stride 4 bits per channel
`define CTL_STRIDE 4
`define CTL_SRC_BIT 0
`define CTL_RATE_BIT 1
`define CTL_REFHALF_BIT 2
`define CTL_BYPASS_BIT 3

// Interrupt status layout: comma events low nibble, character events high nibble
`define IRQ_COMMA_BASE 0
`define IRQ_CHAR_BASE 4

// Reset values
`define CTRL_RST 32'h0000_0000
`define IRQ_MASK_RST 8'h00

// Reference character tick period in clk_in cycles
`define REF_DIV_DEFAULT 10

`endif

// [design/rx_port_pkg.sv]
`include "rx_port_cfg.svh"

package rx_port_pkg;

  localparam int NCH = `NUM_CH;

  typedef struct packed {
    logic strobe;
    logic [9:0] raw;
    logic [7:0] dec;
    logic [2:0] stat;
    logic comma;
  } lane_in_t;

  typedef struct packed {
    logic [7:0] data;
    logic [2:0] status;
  } lane_out_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [31:0] rdata;
    logic irq;
    lane_out_t [NCH-1:0] lane;
    logic [NCH-1:0] clk_t;
    logic [NCH-1:0] clk_n;
  } port_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } div_state_t;

endpackage : rx_port_pkg

// [design/ref_tick_gen.sv]
`timescale 1ns/1ps

`include "rx_port_cfg.svh"

module ref_tick_gen #(
  parameter int DIV = `REF_DIV_DEFAULT
) (
  input wire logic clk_in,
  input wire logic srst_in,
  output logic tick_out
);
  import rx_port_pkg::*;

  localparam logic [15:0] LAST = 16'(DIV - 1);

  div_state_t q;
  div_state_t d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == LAST) begin
      d.cnt = 16'h0000;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_out = q.tick;

endmodule : ref_tick_gen

// [verif/rx_port_checker.sv]
`timescale 1ns/1ps
module rx_port_checker (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input rx_port_pkg::lane_in_t [rx_port_pkg::NCH-1:0] lane_in,
  input rx_port_pkg::lane_out_t [rx_port_pkg::NCH-1:0] rx_char_out,
  input wire logic [rx_port_pkg::NCH-1:0] rx_iface_clock_out,
  input wire logic [rx_port_pkg::NCH-1:0] rx_iface_clock_n_out
);
  import rx_port_pkg::*;
  logic [3:0] c_q;
  // Shadow of channel 0 control nibble
  always_ff @(posedge clk_in) begin
    if (srst_in) c_q <= 4'h0;
    else if (reg_wr_in && reg_addr_in == 8'h00) c_q <= reg_wdata_in[3:0];
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  clock_pair_a: assert property (rx_iface_clock_n_out == ~rx_iface_clock_out) else $error("pair");
  decoded_char_a: assert property (c_q == 4'h0 && lane_in[0].strobe |=>
    rx_char_out[0] == {$past(lane_in[0].dec), $past(lane_in[0].stat)}) else $error("dec");
  raw_char_a: assert property (c_q == 4'h8 && lane_in[0].strobe |=>
    {rx_char_out[0].data, rx_char_out[0].status[1:0]} == $past(lane_in[0].raw)) else $error("raw");
  comma_flag_a: assert property (c_q == 4'h8 && lane_in[0].strobe |=>
    rx_char_out[0].status[2] == $past(lane_in[0].comma)) else $error("comma");
  full_pulse_a: assert property (c_q == 4'h0 && rx_iface_clock_out[0] && !lane_in[0].strobe
    |=> !rx_iface_clock_out[0]) else $error("pulse");
  half_toggle_a: assert property (c_q == 4'h2 && lane_in[0].strobe |=>
    $changed(rx_iface_clock_out[0])) else $error("half");
  char_hold_a: assert property (!c_q[0] && !lane_in[0].strobe |=>
    $stable(rx_char_out[0])) else $error("hold");
  reset_state_a: assert property (disable iff (1'b0) srst_in |=>
    rx_char_out == '0 && rx_iface_clock_out == 4'h0) else $error("reset");
  // Full rate shows a high clock with new data, half rate a toggle
  data_clock_a: assert property ($changed(rx_char_out[0]) |->
    $changed(rx_iface_clock_out[0]) || rx_iface_clock_out[0]) else $error("data moved without clock edge");
  ref_align_a: assert property ($past(c_q) == 4'h1 && $rose(rx_iface_clock_out[0]) |->
    rx_char_out[0] == {$past(lane_in[0].dec), $past(lane_in[0].stat)}) else $error("ref data not aligned");
endmodule : rx_port_checker

// [verif/host_sink.sv]
`timescale 1ns/1ps
module host_sink (
  input wire logic clk_in,
  input wire logic rclk_in,
  input wire logic [7:0] data_in,
  output logic [7:0] seen_out
);
  logic rclk_q;
  always_ff @(posedge clk_in) begin
    rclk_q <= rclk_in;
    if (rclk_in && !rclk_q) seen_out <= data_in;
  end
endmodule : host_sink

// [verif/rx_port_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t %h %h", $time, a, b); end end
module rx_port_tb;
  import rx_port_pkg::*;
  logic clk_in = 0, srst_in = 1, wr = 0, rd = 0, t;
  logic [7:0] addr = 8'h00, seen;
  logic [31:0] wd = 32'h0, rdat;
  lane_in_t [NCH-1:0] lane = '0;
  lane_out_t [NCH-1:0] ch;
  logic [NCH-1:0] ck, ckn;
  logic irq;
  int n_fail = 0, checks = 0, n;
  rx_port #(.REF_DIV(2)) rx_port_inst (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .lane_in(lane), .reg_rdata_out(rdat), .irq_out(irq), .rx_char_out(ch),
    .rx_iface_clock_out(ck), .rx_iface_clock_n_out(ckn));
  host_sink host_sink_inst (.clk_in(clk_in), .rclk_in(ck[0]), .data_in(ch[0].data), .seen_out(seen));
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge clk_in);
    wr <= 0;
    rd <= 0;
    #1;
    if (!w) `CHK(rdat, d)
  endtask : acc
  task automatic st(input int c, input logic [9:0] r);
    @(posedge clk_in);
    lane[c] <= {1'b1, r, r[7:0], r[2:0], r[9]};
    @(posedge clk_in);
    lane[c].strobe <= 0;
    #1;
  endtask : st
  task automatic stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    repeat (20) @(posedge clk_in);
    srst_in <= 0;
    acc(0, 8'h00, 32'h0);
    acc(0, 8'h10, 32'h0);
    acc(1, 8'h0C, 32'h11);
    st(0, 10'h2A5);
    `CHK({ch[0], ck[0], ckn[0], irq}, {11'h52D, 3'b101})
    @(posedge clk_in);
    #1;
    `CHK({ck[0], seen}, {1'b0, 8'hA5})
    acc(1, 8'h08, 32'h10);
    `CHK(irq, 1'b0)
    acc(1, 8'h00, 32'h8);
    st(0, 10'h3F6);
    `CHK({ch[0], irq}, {8'hFD, 3'h6, 1'b1})
    acc(0, 8'h08, 32'h11);
    acc(1, 8'h00, 32'h4);
    st(0, 10'h0AA);
    @(posedge clk_in);
    #1;
    `CHK({ck[0], ch[0].data}, {1'b0, 8'hAA})
    acc(1, 8'h00, 32'h2);
    t = ck[0];
    for (int i = 1; i < 3; i++) begin
      st(0, 10'(i));
      `CHK({ck[0], ch[0].data}, {t ^ i[0], 8'(i)})
    end
    // All true clocks low after an even number of half-rate toggles
    acc(0, 8'h04, 32'h0000_00F0);
    // Tick phase is unknown, so count edges over a whole number of periods
    for (int m = 1; m < 6; m += 4) begin
      acc(1, 8'h00, 32'(m));
      repeat (4) @(posedge clk_in);
      #1;
      t = ck[0];
      n = 0;
      repeat (16) begin
        @(posedge clk_in);
        #1;
        n += int'(ck[0] != t);
        t = ck[0];
      end
      `CHK(n, m == 1 ? 16 : 8)
    end
    st(1, 10'h0C3);
    `CHK({ch[1].data, ck[1]}, {8'hC3, 1'b1})
    @(posedge clk_in);
    srst_in <= 1;
    @(posedge clk_in);
    #1;
    `CHK({ch, ck, ckn, irq}, {48'h0, 4'hF, 1'b0})
    stop_test();
  end
endmodule : rx_port_tb
bind rx_port rx_port_checker rx_port_checker_inst (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .lane_in(lane_in), .rx_char_out(rx_char_out),
  .rx_iface_clock_out(rx_iface_clock_out), .rx_iface_clock_n_out(rx_iface_clock_n_out));
